// ### src/crs_defs.svh
// Constants of the core register set: layout, field positions, offsets
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH

// Widths
`define CRS_W_WORD 16
`define CRS_W_WIDE 20
`define CRS_W_FLAG 11
`define CRS_W_ADDR 8
`define CRS_W_IDX 5

// Physical register slots; slots 0..6 form bank 0, 7..13 bank 1
`define CRS_NUM_PHYS 20
`define CRS_BANK_SIZE 7
`define CRS_P_D0 0
`define CRS_P_D1 1
`define CRS_P_D2 2
`define CRS_P_D3 3
`define CRS_P_A0 4
`define CRS_P_A1 5
`define CRS_P_FB 6
`define CRS_P_VECTOR_TABLE_BASE 14
`define CRS_P_PC 15
`define CRS_P_USP 16
`define CRS_P_ISP 17
`define CRS_P_SB 18
`define CRS_P_FLG 19

// Flag register fields
`define CRS_FLAG_BANK 4
`define CRS_FLAG_STACK 7

// Bus map: slot n sits at byte offset 4*n, then the read-only active SP
`define CRS_OFF_ACTIVE_SP 8'h50
`define CRS_IDX_ACTIVE_SP 6'h14

// Reset value of every register
`define CRS_RST_VAL 20'h00000

// Bus responses
`define CRS_RESP_OKAY 2'b00
`define CRS_RESP_SLVERR 2'b10

`endif

// ### src/crs_pkg.sv
// Types shared by the core register set
package crs_pkg;

	// Register selector used by the decoder on both core ports
	typedef enum logic [4:0] {
		sel_data_reg_0 = 5'h00,
		sel_data_reg_1 = 5'h01,
		sel_data_reg_2 = 5'h02,
		sel_data_reg_3 = 5'h03,
		sel_data0_upper_byte = 5'h04,
		sel_data0_lower_byte = 5'h05,
		sel_data1_upper_byte = 5'h06,
		sel_data1_lower_byte = 5'h07,
		sel_data_pair_low = 5'h08,
		sel_data_pair_high = 5'h09,
		sel_addr_reg_0 = 5'h0a,
		sel_addr_reg_1 = 5'h0b,
		sel_addr_pair = 5'h0c,
		sel_frame_base = 5'h0d,
		sel_vector_table_base = 5'h0e,
		sel_next_instr_addr = 5'h0f,
		sel_user_stack_ptr = 5'h10,
		sel_irq_stack_ptr = 5'h11,
		sel_active_stack_ptr = 5'h12,
		sel_static_base = 5'h13,
		sel_cpu_flags = 5'h14
	} crs_sel_type;

endpackage : crs_pkg

// ### src/crs_word_reg.sv
// One register with separately writable low byte and upper part
`timescale 1ns/100ps
`default_nettype none
`include "crs_defs.svh"

module crs_word_reg #(
	parameter int W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [W-1:0] d,
	output var logic [W-1:0] q
);
	import crs_pkg::*;

	logic [W-1:0] next_q;

	always_comb
	begin
		next_q = q;
		if (wr_lo)
			next_q[7:0] = d[7:0];
		if (wr_hi)
			next_q[W-1:8] = d[W-1:8];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= W'(`CRS_RST_VAL);
		else
			q <= next_q;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_upper_kept: assert property (wr_lo && !wr_hi |=> // RULE_15
		q[W-1:8] == $past(q[W-1:8]) && q[7:0] == $past(d[7:0]))
		else $error("upper part changed on a low byte write");

endmodule : crs_word_reg
`default_nettype wire

// ### src/crs_core_regs.sv
// Core register set: banked data/address registers, bases, PC, stacks
// Behaviour
// (RULE_01) Four 16-bit data registers serve as operands and destinations.
// (RULE_02) Data registers 0 and 1 split into independent upper/lower bytes.
// (RULE_03) Data regs 2:0 and 3:1 combine into two 32-bit pairs.
// (RULE_04) Two 16-bit address registers for indirect/relative addressing.
// (RULE_05) Both address registers combine into one 32-bit pair.
// (RULE_06) A 16-bit frame base register for frame-relative addressing.
// (RULE_07) A 20-bit vector table base register.
// (RULE_08) A 20-bit program counter holding the next instruction address.
// (RULE_09) Two 16-bit stack pointers: user and interrupt.
// (RULE_10) Stack-select flag picks which pointer all stack references use.
// (RULE_11) A 16-bit static base register for static-base addressing.
// (RULE_12) An 11-bit flag register holding stack and bank select flags.
// (RULE_13) Two register banks; bank flag clear picks 0, set picks 1.
// (RULE_14) In a 32-bit pair the higher-named register is the upper half.
// (RULE_15) Writing one byte half leaves the other half unchanged.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "crs_defs.svh"

module crs_core_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic core_wr_en,
	input wire crs_pkg::crs_sel_type core_wr_sel,
	input wire logic [31:0] core_wr_data,
	input wire crs_pkg::crs_sel_type core_rd_sel,
	output logic [31:0] core_rd_data,
	output logic [15:0] active_stack_ptr,
	output logic [19:0] next_instr_addr,
	output logic [19:0] vector_table_base,
	output logic [15:0] frame_base,
	output logic [15:0] static_base,
	output logic [10:0] cpu_flags,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import crs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [19:0] reg_q [`CRS_NUM_PHYS];
	logic [19:0] wr_data [`CRS_NUM_PHYS];
	logic [`CRS_NUM_PHYS-1:0] wr_lo;
	logic [`CRS_NUM_PHYS-1:0] wr_hi;
	logic [4:0] bank_base;
	logic stack_irq;

	// Slot widths: flags 11, table base and PC 20, the rest 16
	for (genvar i = 0; i < `CRS_NUM_PHYS; i++)
	begin : g_reg
		localparam int PW = (i == `CRS_P_FLG) ? `CRS_W_FLAG :
			((i == `CRS_P_VECTOR_TABLE_BASE || i == `CRS_P_PC) ? `CRS_W_WIDE :
			`CRS_W_WORD);
		logic [PW-1:0] q;
		crs_word_reg #(.W(PW)) u_reg (
			.aclk(aclk),
			.aresetn(aresetn),
			.wr_lo(wr_lo[i]),
			.wr_hi(wr_hi[i]),
			.d(wr_data[i][PW-1:0]),
			.q(q)
		);
		assign reg_q[i] = 20'(q);
	end

	assign cpu_flags = reg_q[`CRS_P_FLG][10:0]; // RULE_12
	// Bank flag moves every banked slot reference by one bank
	assign bank_base = cpu_flags[`CRS_FLAG_BANK] ?
		5'(`CRS_BANK_SIZE) : 5'h00; // RULE_13
	assign stack_irq = cpu_flags[`CRS_FLAG_STACK];
	assign active_stack_ptr = stack_irq ? reg_q[`CRS_P_ISP][15:0] :
		reg_q[`CRS_P_USP][15:0]; // RULE_10
	assign next_instr_addr = reg_q[`CRS_P_PC]; // RULE_08
	assign vector_table_base = reg_q[`CRS_P_VECTOR_TABLE_BASE]; // RULE_07
	assign frame_base = reg_q[bank_base + 5'(`CRS_P_FB)][15:0]; // RULE_06
	assign static_base = reg_q[`CRS_P_SB][15:0]; // RULE_11

	////////////////////////////////////////////////////////////////////////
	// Write decode: core port first, bus write only in idle core cycles

	logic [4:0] tgt_a;
	logic [4:0] tgt_b;
	logic [19:0] dat_a;
	logic [19:0] dat_b;
	logic [1:0] en_a;
	logic [1:0] en_b;
	logic aw_full;
	logic [5:0] aw_idx;
	logic w_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic axi_wr_go;

	always_comb
	begin
		tgt_a = 5'h00;
		tgt_b = 5'h00;
		en_a = 2'b00;
		en_b = 2'b00;
		dat_a = core_wr_data[19:0];
		dat_b = 20'(core_wr_data[31:16]);
		axi_wr_go = 1'b0;
		if (core_wr_en)
		begin
			unique case (core_wr_sel)
				sel_data_reg_0, sel_data_reg_1, sel_data_reg_2,
				sel_data_reg_3:
				begin
					tgt_a = bank_base + core_wr_sel; // RULE_01
					en_a = 2'b11;
				end
				sel_data0_upper_byte, sel_data1_upper_byte:
				begin
					tgt_a = bank_base + 5'(core_wr_sel[1]); // RULE_02
					en_a = 2'b10; // RULE_15
					dat_a = {4'h0, core_wr_data[7:0], 8'h00};
				end
				sel_data0_lower_byte, sel_data1_lower_byte:
				begin
					tgt_a = bank_base + 5'(core_wr_sel[1]); // RULE_02
					en_a = 2'b01; // RULE_15
				end
				sel_data_pair_low, sel_data_pair_high:
				begin
					// Upper word to reg 2 or 3, lower word to reg 0 or 1
					tgt_a = bank_base + 5'(core_wr_sel[0]); // RULE_03
					tgt_b = bank_base + 5'(`CRS_P_D2) +
						5'(core_wr_sel[0]); // RULE_14
					en_a = 2'b11;
					en_b = 2'b11;
				end
				sel_addr_reg_0:
				begin
					tgt_a = bank_base + 5'(`CRS_P_A0); // RULE_04
					en_a = 2'b11;
				end
				sel_addr_reg_1:
				begin
					tgt_a = bank_base + 5'(`CRS_P_A1); // RULE_04
					en_a = 2'b11;
				end
				sel_addr_pair:
				begin
					tgt_a = bank_base + 5'(`CRS_P_A0); // RULE_05
					tgt_b = bank_base + 5'(`CRS_P_A1);
					en_a = 2'b11;
					en_b = 2'b11;
				end
				sel_frame_base:
				begin
					tgt_a = bank_base + 5'(`CRS_P_FB); // RULE_06
					en_a = 2'b11;
				end
				sel_vector_table_base:
				begin
					tgt_a = 5'(`CRS_P_VECTOR_TABLE_BASE); // RULE_07
					en_a = 2'b11;
				end
				sel_next_instr_addr:
				begin
					tgt_a = 5'(`CRS_P_PC); // RULE_08
					en_a = 2'b11;
				end
				sel_user_stack_ptr:
				begin
					tgt_a = 5'(`CRS_P_USP); // RULE_09
					en_a = 2'b11;
				end
				sel_irq_stack_ptr:
				begin
					tgt_a = 5'(`CRS_P_ISP); // RULE_09
					en_a = 2'b11;
				end
				sel_active_stack_ptr:
				begin
					tgt_a = stack_irq ? 5'(`CRS_P_ISP) :
						5'(`CRS_P_USP); // RULE_10
					en_a = 2'b11;
				end
				sel_static_base:
				begin
					tgt_a = 5'(`CRS_P_SB); // RULE_11
					en_a = 2'b11;
				end
				sel_cpu_flags:
				begin
					tgt_a = 5'(`CRS_P_FLG); // RULE_12
					en_a = 2'b11;
				end
				default:
				begin
					en_a = 2'b00;
				end
			endcase
		end
		else if (aw_full && w_full && !s_axi_bvalid)
		begin
			// Bus writes see the flat map of both banks
			axi_wr_go = 1'b1;
			if (aw_idx < 6'(`CRS_NUM_PHYS))
			begin
				tgt_a = aw_idx[4:0];
				en_a = {|w_strb[2:1], w_strb[0]};
				dat_a = w_data[19:0];
			end
		end
	end

	always_comb
	begin
		for (int i = 0; i < `CRS_NUM_PHYS; i++)
		begin
			wr_lo[i] = (tgt_a == 5'(i) && en_a[0]) ||
				(tgt_b == 5'(i) && en_b[0]);
			wr_hi[i] = (tgt_a == 5'(i) && en_a[1]) ||
				(tgt_b == 5'(i) && en_b[1]);
			wr_data[i] = (tgt_b == 5'(i) && en_b != 2'b00) ? dat_b : dat_a;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core read port, one cycle of latency

	logic [31:0] next_core_rd_data;
	logic [4:0] rd_base;

	always_comb
	begin
		rd_base = 5'h00;
		next_core_rd_data = 32'h0000_0000;
		unique case (core_rd_sel)
			sel_data_reg_0, sel_data_reg_1, sel_data_reg_2,
			sel_data_reg_3:
				next_core_rd_data = 32'(reg_q[bank_base + core_rd_sel]);
			sel_data0_upper_byte, sel_data1_upper_byte:
			begin
				rd_base = bank_base + 5'(core_rd_sel[1]);
				next_core_rd_data = 32'(reg_q[rd_base][15:8]);
			end
			sel_data0_lower_byte, sel_data1_lower_byte:
			begin
				rd_base = bank_base + 5'(core_rd_sel[1]);
				next_core_rd_data = 32'(reg_q[rd_base][7:0]);
			end
			sel_data_pair_low, sel_data_pair_high:
			begin
				rd_base = bank_base + 5'(core_rd_sel[0]);
				next_core_rd_data = {reg_q[rd_base + 5'(`CRS_P_D2)][15:0],
					reg_q[rd_base][15:0]}; // RULE_14
			end
			sel_addr_reg_0:
				next_core_rd_data = 32'(reg_q[bank_base + 5'(`CRS_P_A0)]);
			sel_addr_reg_1:
				next_core_rd_data = 32'(reg_q[bank_base + 5'(`CRS_P_A1)]);
			sel_addr_pair:
				next_core_rd_data = {reg_q[bank_base + 5'(`CRS_P_A1)][15:0],
					reg_q[bank_base + 5'(`CRS_P_A0)][15:0]}; // RULE_05
			sel_frame_base:
				next_core_rd_data = 32'(frame_base);
			sel_vector_table_base:
				next_core_rd_data = 32'(vector_table_base);
			sel_next_instr_addr:
				next_core_rd_data = 32'(next_instr_addr);
			sel_user_stack_ptr:
				next_core_rd_data = 32'(reg_q[`CRS_P_USP]);
			sel_irq_stack_ptr:
				next_core_rd_data = 32'(reg_q[`CRS_P_ISP]);
			sel_active_stack_ptr:
				next_core_rd_data = 32'(active_stack_ptr); // RULE_10
			sel_static_base:
				next_core_rd_data = 32'(static_base);
			sel_cpu_flags:
				next_core_rd_data = 32'(cpu_flags);
			default:
				next_core_rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			core_rd_data <= 32'h0000_0000;
		else
			core_rd_data <= next_core_rd_data;
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic next_aw_full;
	logic [5:0] next_aw_idx;
	logic next_w_full;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [5:0] ar_idx;

	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx = s_axi_araddr[7:2];

	always_comb
	begin
		next_aw_full = aw_full;
		next_aw_idx = aw_idx;
		next_w_full = w_full;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid && !s_axi_bready;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_awvalid && !aw_full)
		begin
			next_aw_full = 1'b1;
			next_aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && !w_full)
		begin
			next_w_full = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (axi_wr_go)
		begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_idx < 6'(`CRS_NUM_PHYS)) ?
				`CRS_RESP_OKAY : `CRS_RESP_SLVERR;
		end
		if (s_axi_arvalid && !s_axi_rvalid)
		begin
			next_rvalid = 1'b1;
			next_rresp = `CRS_RESP_OKAY;
			if (ar_idx < 6'(`CRS_NUM_PHYS))
				next_rdata = 32'(reg_q[ar_idx[4:0]]);
			else if (ar_idx == `CRS_IDX_ACTIVE_SP)
				next_rdata = 32'(active_stack_ptr);
			else
			begin
				next_rdata = 32'h0000_0000;
				next_rresp = `CRS_RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			aw_idx <= 6'h00;
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CRS_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `CRS_RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			aw_idx <= next_aw_idx;
			w_full <= next_w_full;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_data_word_write: assert property (core_wr_en && // RULE_01
		core_wr_sel == sel_data_reg_3 && !cpu_flags[`CRS_FLAG_BANK] |=>
		reg_q[`CRS_P_D3][15:0] == $past(core_wr_data[15:0]))
		else $error("data register 3 did not take the word");
	a_upper_byte_write: assert property (core_wr_en && // RULE_02
		core_wr_sel == sel_data1_upper_byte &&
		!cpu_flags[`CRS_FLAG_BANK] |=>
		reg_q[`CRS_P_D1][15:8] == $past(core_wr_data[7:0]) &&
		$stable(reg_q[`CRS_P_D1][7:0]))
		else $error("upper byte write went wrong");
	a_pair_halves: assert property (core_wr_en && // RULE_03
		core_wr_sel == sel_data_pair_high &&
		!cpu_flags[`CRS_FLAG_BANK] |=>
		reg_q[`CRS_P_D3][15:0] == $past(core_wr_data[31:16]) &&
		reg_q[`CRS_P_D1][15:0] == $past(core_wr_data[15:0]))
		else $error("pair halves swapped or lost");
	a_pair_read_order: assert property (core_rd_sel == sel_addr_pair && // RULE_05
		!core_wr_en |=> core_rd_data ==
		{$past(reg_q[bank_base + 5'(`CRS_P_A1)][15:0]),
		$past(reg_q[bank_base + 5'(`CRS_P_A0)][15:0])})
		else $error("address pair read in wrong order");
	a_stack_select: assert property (core_wr_en && // RULE_10
		core_wr_sel == sel_active_stack_ptr && stack_irq |=>
		reg_q[`CRS_P_ISP][15:0] == $past(core_wr_data[15:0]) &&
		$stable(reg_q[`CRS_P_USP]))
		else $error("active stack write reached the wrong pointer");
	a_pc_full_width: assert property (core_wr_en && // RULE_08
		core_wr_sel == sel_next_instr_addr |=>
		next_instr_addr == $past(core_wr_data[19:0]))
		else $error("program counter lost bits");
	a_bank_isolated: assert property (core_wr_en && // RULE_13
		core_wr_sel == sel_data_reg_0 && cpu_flags[`CRS_FLAG_BANK] |=>
		$stable(reg_q[`CRS_P_D0]) &&
		reg_q[`CRS_BANK_SIZE][15:0] == $past(core_wr_data[15:0]))
		else $error("bank one write reached bank zero");
	a_bus_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read answer missing");

	c_bank_one: cover property (core_wr_en && cpu_flags[`CRS_FLAG_BANK]);
	c_irq_stack: cover property (core_wr_en && stack_irq &&
		core_wr_sel == sel_active_stack_ptr);
	c_bus_write: cover property (axi_wr_go ##1 s_axi_bvalid);
	c_bus_stalled: cover property (core_wr_en && aw_full && w_full);

endmodule : crs_core_regs
`default_nettype wire

// ### dv/crs_core_model.sv
// Behavioural decoder that drives the core-side register ports
`timescale 1ns/100ps
`default_nettype none

module crs_core_model (
	input wire logic aclk,
	output var logic core_wr_en,
	output var crs_pkg::crs_sel_type core_wr_sel,
	output var logic [31:0] core_wr_data,
	output var crs_pkg::crs_sel_type core_rd_sel,
	input wire logic [31:0] core_rd_data
);
	import crs_pkg::*;

	initial
	begin
		core_wr_en = 1'h0;
		core_wr_sel = sel_data_reg_0;
		core_wr_data = 32'h0;
		core_rd_sel = sel_data_reg_0;
	end

	// One write strobe per call, taken at the next rising edge
	task automatic put(input crs_sel_type s, input logic [31:0] d);
		@(posedge aclk);
		core_wr_en <= 1'h1;
		core_wr_sel <= s;
		core_wr_data <= d;
		@(posedge aclk);
		core_wr_en <= 1'h0;
		// Idle data bus must not keep showing the value just written
		core_wr_data <= ~d;
	endtask : put

	// Read data is registered, so it is valid one edge after the select
	task automatic get(input crs_sel_type s, output logic [31:0] d);
		@(posedge aclk);
		core_rd_sel <= s;
		@(posedge aclk);
		@(negedge aclk);
		d = core_rd_data;
	endtask : get

endmodule : crs_core_model
`default_nettype wire

// ### dv/cpu_core_register_set_test.sv
// Self-checking bench for the core register set
`timescale 1ns/100ps
`default_nettype none
`include "crs_defs.svh"

`define CHK(got, want) \
	begin \
		n_tests++; \
		if ((got) !== (want)) \
		begin \
			miscompares++; \
			$display("unexpected at %0t: got %h want %h", $time, got, want); \
		end \
	end

module cpu_core_register_set_test;
	import crs_pkg::*;

	typedef struct {
		crs_sel_type ws;
		logic [31:0] wd;
		crs_sel_type rs;
		logic [31:0] ex;
	} crs_row_type;

	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic core_wr_en;
	crs_sel_type core_wr_sel;
	crs_sel_type core_rd_sel;
	logic [31:0] core_wr_data;
	logic [31:0] core_rd_data;
	logic [15:0] active_stack_ptr;
	logic [15:0] frame_base;
	logic [15:0] static_base;
	logic [19:0] next_instr_addr;
	logic [19:0] vector_table_base;
	logic [10:0] cpu_flags;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp;
	logic [1:0] s_axi_rresp;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic s_axi_awready;
	logic s_axi_wready;
	logic s_axi_bvalid;
	logic s_axi_arready;
	logic s_axi_rvalid;
	int miscompares = 0;
	int n_tests = 0;
	logic [31:0] rd;
	logic [1:0] rsp;

	// Rows run in order; each expectation includes the effect of earlier rows
	crs_row_type rows [26] = '{
		'{sel_data_reg_0, 32'h1234, sel_data_reg_0, 32'h1234},
		'{sel_data_reg_1, 32'habcd, sel_data_reg_1, 32'habcd},
		'{sel_data_reg_2, 32'h5a5a, sel_data_reg_2, 32'h5a5a},
		'{sel_data_reg_3, 32'ha5a5, sel_data_pair_high, 32'ha5a5abcd},
		'{sel_data0_upper_byte, 32'h77, sel_data_reg_0, 32'h7734},
		'{sel_data1_lower_byte, 32'h11, sel_data_reg_1, 32'hab11},
		'{sel_data1_upper_byte, 32'h22, sel_data1_lower_byte, 32'h11},
		'{sel_data0_lower_byte, 32'hee, sel_data0_upper_byte, 32'h77},
		'{sel_data_pair_low, 32'hdeadbeef, sel_data_reg_2, 32'hdead},
		'{sel_addr_reg_1, 32'h1111, sel_addr_reg_1, 32'h1111},
		'{sel_addr_reg_0, 32'h3333, sel_addr_pair, 32'h11113333},
		'{sel_addr_pair, 32'h89abcdef, sel_addr_reg_0, 32'hcdef},
		'{sel_frame_base, 32'h4444, sel_frame_base, 32'h4444},
		'{sel_vector_table_base, 32'hfff12345,
			sel_vector_table_base, 32'h12345},
		'{sel_next_instr_addr, 32'habcde,
			sel_next_instr_addr, 32'habcde},
		'{sel_user_stack_ptr, 32'h5555, sel_active_stack_ptr, 32'h5555},
		'{sel_user_stack_ptr, 32'h5555, sel_user_stack_ptr, 32'h5555},
		'{sel_irq_stack_ptr, 32'h6666, sel_irq_stack_ptr, 32'h6666},
		'{sel_static_base, 32'h7777, sel_static_base, 32'h7777},
		'{sel_cpu_flags, 32'hffffffff, sel_cpu_flags, 32'h7ff},
		'{sel_cpu_flags, 32'h80, sel_active_stack_ptr, 32'h6666},
		'{sel_active_stack_ptr, 32'h0123, sel_irq_stack_ptr, 32'h0123},
		'{sel_cpu_flags, 32'h10, sel_data_reg_0, 32'h0},
		'{sel_data_reg_0, 32'h9999, sel_data_reg_0, 32'h9999},
		'{sel_cpu_flags, 32'h0, sel_data_pair_low, 32'hdeadbeef},
		'{sel_data_pair_high, 32'h13572468, sel_data_reg_3, 32'h1357}
	};

	always #2 aclk = ~aclk;

	crs_core_regs DUT (.aclk(aclk), .aresetn(aresetn),
		.core_wr_en(core_wr_en), .core_wr_sel(core_wr_sel),
		.core_wr_data(core_wr_data), .core_rd_sel(core_rd_sel),
		.core_rd_data(core_rd_data), .active_stack_ptr(active_stack_ptr),
		.next_instr_addr(next_instr_addr),
		.vector_table_base(vector_table_base), .frame_base(frame_base),
		.static_base(static_base), .cpu_flags(cpu_flags),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	crs_core_model core (.aclk(aclk), .core_wr_en(core_wr_en),
		.core_wr_sel(core_wr_sel), .core_wr_data(core_wr_data),
		.core_rd_sel(core_rd_sel), .core_rd_data(core_rd_data));

	task automatic give_verdict();
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// Handshakes are judged at the falling edge: inputs only move on rising
	// Bready rises only once bvalid is seen, so the slave must hold it
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, output logic [1:0] r);
		bit ha;
		bit hw;
		bit hb;
		bit bv;
		hb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'h1;
		while (!hb)
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid && s_axi_bready;
			bv = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'h0;
			if (hw)
				s_axi_wvalid <= 1'h0;
			if (hb)
				s_axi_bready <= 1'h0;
			else if (bv)
				s_axi_bready <= 1'h1;
		end
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit ha;
		bit hr;
		hr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!hr)
		begin
			@(negedge aclk);
			ha = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid && s_axi_rready;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ha)
				s_axi_arvalid <= 1'h0;
			if (hr)
				s_axi_rready <= 1'h0;
		end
	endtask : axr

	initial
	begin
		#20000;
		miscompares++;
		give_verdict();
	end

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		`CHK(cpu_flags, 11'h000)
		`CHK(next_instr_addr, 20'h00000)
		axr(8'h44, rd, rsp);
		`CHK(rd, 32'h0)
		foreach (rows[i])
		begin
			core.put(rows[i].ws, rows[i].wd);
			core.get(rows[i].rs, rd);
			`CHK(rd, rows[i].ex)
		end
		`CHK(vector_table_base, 20'h12345)
		`CHK(static_base, 16'h7777)
		`CHK(frame_base, 16'h4444)
		`CHK(active_stack_ptr, 16'h5555)
		core.put(sel_cpu_flags, 32'h10);
		@(negedge aclk);
		`CHK(frame_base, 16'h0000)
		core.put(sel_cpu_flags, 32'h0);
		axr(8'h00, rd, rsp);
		`CHK(rd, 32'h0000beef)
		`CHK(rsp, `CRS_RESP_OKAY)
		axr(8'h1c, rd, rsp);
		`CHK(rd, 32'h00009999)
		axw(8'h3c, 32'hffffffff, 4'h1, rsp);
		`CHK(rsp, `CRS_RESP_OKAY)
		`CHK(next_instr_addr, 20'habcff)
		axw(8'h40, 32'h2468, 4'hf, rsp);
		`CHK(active_stack_ptr, 16'h2468)
		axr(`CRS_OFF_ACTIVE_SP, rd, rsp);
		`CHK(rd, 32'h2468)
		axr(8'h54, rd, rsp);
		`CHK(rsp, `CRS_RESP_SLVERR)
		`CHK(rd, 32'h0)
		axw(`CRS_OFF_ACTIVE_SP, 32'h1357, 4'hf, rsp);
		`CHK(rsp, `CRS_RESP_SLVERR)
		`CHK(active_stack_ptr, 16'h2468)
		// Core write lands while the bus write is ready: the bus waits
		fork
			axw(8'h48, 32'h0bad, 4'hf, rsp);
			begin
				@(posedge aclk);
				core.put(sel_static_base, 32'h0abc);
			end
		join
		`CHK(rsp, `CRS_RESP_OKAY)
		`CHK(static_base, 16'h0bad)
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		`CHK(next_instr_addr, 20'h00000)
		`CHK(active_stack_ptr, 16'h0000)
		give_verdict();
	end

endmodule : cpu_core_register_set_test
`default_nettype wire
